// ==== design/serial_flash_sequencer.sv ====
// Purpose: program, erase and power-down command sequencer of a serial flash
// Assumes: host drives chip select, serial clock and data; array is outside
// Notes:   protection of an address is judged outside via targetProtected
//
// Summary of operation
// - quad program needs the quad enable bit
// - program or erase needs the write enable latch
// - quad program: opcode, three address bytes, data
// - over 256 bytes: only the last 256 kept
// - short program touches only the addressed bytes
// - program runs only if deselected on byte boundary
// - deselect starts cycle; busy flag; latch cleared
// - no program into a protected page
// - sector erase opcode with any address inside
// - erase runs only if deselected after address
// - 32KB and 64KB block erase opcodes decoded
// - no erase of a protected region
// - chip erase: lone opcode ending on its bit
// - chip erase only with no region protected
// - sleep opcode enters deep power-down after delay
// - asleep: only wake and reset pair accepted
// - sleep rejected while a cycle runs
// - standby after reset; deselect never sleeps
// - wake alone resumes after the wake delay
// - wake with dummies repeats identifier msb first
// - wake with identifier resumes after its delay
// - wake ignored while a cycle runs
// - program data wraps within its page
`timescale 1ns/1ps

module serial_flash_sequencer #(
  parameter int unsigned PROG_CYCLES    = `T_PROG_US * 1000 / `CLK_PERIOD_NS,
  parameter int unsigned SECT_CYCLES    = `T_SECT_MS * 1000000 / `CLK_PERIOD_NS,
  parameter int unsigned BLK32_CYCLES   = `T_BLK32_MS * 1000000 / `CLK_PERIOD_NS,
  parameter int unsigned BLK64_CYCLES   = `T_BLK64_MS * 1000000 / `CLK_PERIOD_NS,
  parameter int unsigned CHIP_CYCLES    = `T_CHIP_MS * 1000000 / `CLK_PERIOD_NS,
  parameter int unsigned SLEEP_CYCLES   = (`T_SLEEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int unsigned WAKE_CYCLES    = (`T_WAKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int unsigned WAKE_ID_CYCLES = (`T_WAKE_ID_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter logic [7:0]  DEVICE_ID      = 8'h5a  // arbitrary value
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // flash pins
  input  wire logic        chipSelectN,
  input  wire logic        serialClk,
  input  wire logic [3:0]  quadDataIn,
  output logic      [3:0]  quadDataOut,
  output logic      [3:0]  quadDataOe,
  // configuration
  input  wire logic        quadEnableBit,
  input  wire logic [4:0]  blockProtectBits,
  input  wire logic        protectComplementBit,
  // protection query
  output logic      [23:0] targetAddr,
  output logic      [2:0]  targetKind,
  input  wire logic        targetProtected,
  // status
  output logic             writeInProgressFlag,
  output logic             writeEnableLatch,
  output logic             deepPowerDown,
  // array side
  output logic             opStart,
  output logic      [2:0]  opKind,
  output logic      [23:0] opAddr,
  input  wire logic [7:0]  pageRdIdx,
  output logic      [7:0]  pageRdData,
  output logic             pageRdValid
);

  // ****************************************************************
  // decoding helpers
  // ****************************************************************
  function automatic logic [2:0] kindOf(input logic [7:0] opc);
    unique case (opc)
      `OPC_QUAD_PROG:                    kindOf = `OPK_PROG;
      `OPC_SECT_WIPE:                    kindOf = `OPK_SECT;
      `OPC_BLK32_WIPE:                   kindOf = `OPK_BLK32;
      `OPC_BLK64_WIPE:                   kindOf = `OPK_BLK64;
      `OPC_CHIP_WIPE_A, `OPC_CHIP_WIPE_B: kindOf = `OPK_CHIP;
      default:                           kindOf = `OPK_NONE;
    endcase
  endfunction : kindOf

  function automatic logic chipClear(input logic [2:0] bp, input logic cmp);
    chipClear = (bp == 3'h0 && !cmp) || (bp == 3'h7 && cmp);
  endfunction : chipClear

  // ****************************************************************
  // submodules
  // ****************************************************************
  cmd_link_if lk ();

  logic tBusy;
  logic tDone;

  flash_seq_pkg::seq_s st;
  flash_seq_pkg::seq_s next_st;

  spi_shifter u_shifter (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .chipSelectN (chipSelectN),
    .serialClk   (serialClk),
    .quadDataIn  (quadDataIn),
    .lk          (lk.rx)
  );

  wait_timer u_timer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .start   (st.tStart),
    .load    (st.tLoad),
    .busy    (tBusy),
    .done    (tDone)
  );

  // ****************************************************************
  // command sequencing
  // ****************************************************************
  always_comb begin
    logic        busy;
    logic        endOk;
    logic        go;
    logic [2:0]  goKind;
    flash_seq_pkg::use_e goUse;
    logic [31:0] goLoad;
    busy = st.job != flash_seq_pkg::USE_NONE;
    endOk = lk.csRise && !lk.partial;
    go = 1'b0;
    goKind = `OPK_NONE;
    goUse = flash_seq_pkg::USE_NONE;
    goLoad = 32'h0;
    next_st = st;
    next_st.opStart = 1'b0;
    next_st.tStart = 1'b0;

    if (lk.rxValid) begin
      unique case (st.phase)
        flash_seq_pkg::PH_OPCODE: begin
          next_st.opcode = lk.rxByte;
          next_st.cnt = 2'h0;
          if (busy) begin
            next_st.phase = flash_seq_pkg::PH_IGNORE;
          end else if (st.dpd) begin
            unique case (lk.rxByte)
              `OPC_WAKE_ID:             next_st.phase = flash_seq_pkg::PH_DUMMY;
              `OPC_RST_ENABLE, `OPC_RST: next_st.phase = flash_seq_pkg::PH_DONE;
              default:                  next_st.phase = flash_seq_pkg::PH_IGNORE;
            endcase
          end else begin
            unique case (lk.rxByte)
              `OPC_QUAD_PROG, `OPC_SECT_WIPE, `OPC_BLK32_WIPE, `OPC_BLK64_WIPE:
                next_st.phase = flash_seq_pkg::PH_ADDR;
              `OPC_WR_ENABLE, `OPC_WR_DISABLE, `OPC_CHIP_WIPE_A, `OPC_CHIP_WIPE_B,
              `OPC_SLEEP, `OPC_RST_ENABLE, `OPC_RST:
                next_st.phase = flash_seq_pkg::PH_DONE;
              `OPC_WAKE_ID:
                next_st.phase = flash_seq_pkg::PH_DUMMY;
              default:
                next_st.phase = flash_seq_pkg::PH_IGNORE;
            endcase
          end
        end
        flash_seq_pkg::PH_ADDR: begin
          next_st.addr = {st.addr[15:0], lk.rxByte};
          next_st.cnt = st.cnt + 2'h1;
          if (st.cnt == `LAST_ADDR_BYTE) begin
            if (st.opcode == `OPC_QUAD_PROG) begin
              next_st.phase = flash_seq_pkg::PH_DATA;
              next_st.quad = 1'b1;
              next_st.ptr = lk.rxByte;
              next_st.anyData = 1'b0;
              next_st.pageValid = '0;
            end else begin
              next_st.phase = flash_seq_pkg::PH_DONE;
            end
          end
        end
        flash_seq_pkg::PH_DATA: begin
          next_st.pageBuf[st.ptr] = lk.rxByte;
          next_st.pageValid[st.ptr] = 1'b1;
          next_st.ptr = st.ptr + 8'h1;
          next_st.anyData = 1'b1;
        end
        flash_seq_pkg::PH_DONE: begin
          next_st.phase = flash_seq_pkg::PH_IGNORE;
        end
        flash_seq_pkg::PH_DUMMY: begin
          next_st.cnt = st.cnt + 2'h1;
          if (st.cnt == `LAST_DUMMY) begin
            next_st.phase = flash_seq_pkg::PH_ID;
            next_st.idBit = `ID_MSB;
          end
        end
        flash_seq_pkg::PH_ID, flash_seq_pkg::PH_IGNORE: begin
        end
      endcase
    end

    // identifier readout on falling serial clock
    if (st.phase == flash_seq_pkg::PH_ID && lk.sclkFall) begin
      next_st.dout = DEVICE_ID[st.idBit];
      next_st.doutEn = 1'b1;
      next_st.idBit = st.idBit - 3'h1;
    end

    // deselect: judge the finished command
    if (lk.csRise) begin
      next_st.phase = flash_seq_pkg::PH_OPCODE;
      next_st.quad = 1'b0;
      next_st.doutEn = 1'b0;
      next_st.cnt = 2'h0;
      next_st.rstArmed = 1'b0;
      if (endOk && st.phase == flash_seq_pkg::PH_DONE) begin
        unique case (st.opcode)
          `OPC_WR_ENABLE:  next_st.write_enable_latch = 1'b1;
          `OPC_WR_DISABLE: next_st.write_enable_latch = 1'b0;
          `OPC_RST_ENABLE: next_st.rstArmed = 1'b1;
          `OPC_RST: begin
            if (st.rstArmed) begin
              next_st.dpd = 1'b0;
              next_st.write_enable_latch = 1'b0;
            end
          end
          `OPC_SLEEP: begin
            go = !busy;
            goUse = flash_seq_pkg::USE_SLEEP;
            goLoad = 32'(SLEEP_CYCLES);
          end
          `OPC_CHIP_WIPE_A, `OPC_CHIP_WIPE_B: begin
            go = st.write_enable_latch && chipClear(blockProtectBits[2:0], protectComplementBit);
            goUse = flash_seq_pkg::USE_WORK;
            goKind = `OPK_CHIP;
            goLoad = 32'(CHIP_CYCLES);
          end
          `OPC_SECT_WIPE, `OPC_BLK32_WIPE, `OPC_BLK64_WIPE: begin
            go = st.write_enable_latch && !targetProtected;
            goUse = flash_seq_pkg::USE_WORK;
            goKind = kindOf(st.opcode);
            unique case (st.opcode)
              `OPC_SECT_WIPE:  goLoad = 32'(SECT_CYCLES);
              `OPC_BLK32_WIPE: goLoad = 32'(BLK32_CYCLES);
              default:         goLoad = 32'(BLK64_CYCLES);
            endcase
          end
          default: begin
          end
        endcase
      end
      if (endOk && st.phase == flash_seq_pkg::PH_DATA && st.anyData) begin
        go = st.write_enable_latch && quadEnableBit && !targetProtected;
        goUse = flash_seq_pkg::USE_WORK;
        goKind = `OPK_PROG;
        goLoad = 32'(PROG_CYCLES);
      end
      if (st.dpd && !busy && st.opcode == `OPC_WAKE_ID &&
          (st.phase == flash_seq_pkg::PH_DUMMY || st.phase == flash_seq_pkg::PH_ID)) begin
        go = 1'b1;
        goUse = flash_seq_pkg::USE_WAKE;
        goLoad = (st.phase == flash_seq_pkg::PH_DUMMY && st.cnt == 2'h0) ?
                 32'(WAKE_CYCLES) : 32'(WAKE_ID_CYCLES);
      end
    end

    // start a timed cycle
    if (go) begin
      next_st.job = goUse;
      next_st.tStart = 1'b1;
      next_st.tLoad = goLoad;
      if (goUse == flash_seq_pkg::USE_WORK) begin
        next_st.write_enable_latch = 1'b0;
        next_st.opStart = 1'b1;
        next_st.opKind = goKind;
        next_st.opAddr = st.addr;
      end
    end

    // end of a timed cycle
    if (tDone) begin
      next_st.job = flash_seq_pkg::USE_NONE;
      if (st.job == flash_seq_pkg::USE_SLEEP) begin
        next_st.dpd = 1'b1;
      end
      if (st.job == flash_seq_pkg::USE_WAKE) begin
        next_st.dpd = 1'b0;
      end
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= '{phase: flash_seq_pkg::PH_OPCODE, job: flash_seq_pkg::USE_NONE,
              write_enable_latch: `WEL_RESET, dpd: `DPD_RESET, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign lk.quadMode           = st.quad;
  assign quadDataOut           = {2'b00, st.dout, 1'b0};
  assign quadDataOe            = {2'b00, st.doutEn, 1'b0};
  assign targetAddr            = st.addr;
  assign targetKind            = kindOf(st.opcode);
  assign writeInProgressFlag   = st.job == flash_seq_pkg::USE_WORK;
  assign writeEnableLatch      = st.write_enable_latch;
  assign deepPowerDown         = st.dpd;
  assign opStart               = st.opStart;
  assign opKind                = st.opKind;
  assign opAddr                = st.opAddr;
  assign pageRdData            = st.pageBuf[pageRdIdx];
  assign pageRdValid           = st.pageValid[pageRdIdx];

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_work_begin;
    st.opStart && st.opKind != `OPK_NONE;
  endsequence

  sequence s_busy_then;
    ##1 (writeInProgressFlag && !st.write_enable_latch) ##1 writeInProgressFlag;
  endsequence

  property p_qe_gate;
    s_work_begin and (st.opKind == `OPK_PROG) |-> $past(quadEnableBit);
  endproperty
  a_qe_gate: assert property (p_qe_gate) else $error("program without quad enable");

  property p_wel_gate;
    s_work_begin |-> $past(st.write_enable_latch);
  endproperty
  a_wel_gate: assert property (p_wel_gate) else $error("cycle without write enable");

  property p_boundary;
    s_work_begin |-> $past(lk.csRise) && !$past(lk.partial);
  endproperty
  a_boundary: assert property (p_boundary) else $error("start off a byte boundary");

  property p_busy;
    s_work_begin |-> s_busy_then;
  endproperty
  a_busy: assert property (p_busy) else $error("busy flag not raised");

  property p_busy_end;
    $fell(writeInProgressFlag) |-> $past(tDone) && !st.write_enable_latch;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy flag fell early");

  property p_protect;
    s_work_begin and (st.opKind != `OPK_CHIP) |-> !$past(targetProtected);
  endproperty
  a_protect: assert property (p_protect) else $error("protected target started");

  property p_chip;
    s_work_begin and (st.opKind == `OPK_CHIP) |->
      $past(chipClear(blockProtectBits[2:0], protectComplementBit));
  endproperty
  a_chip: assert property (p_chip) else $error("chip erase with protection");

  property p_sleep_entry;
    $rose(st.dpd) |-> $past(tDone) && !writeInProgressFlag;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep without delay");

  property p_no_work_asleep;
    st.dpd |-> !st.opStart;
  endproperty
  a_no_work_asleep: assert property (p_no_work_asleep) else $error("work while asleep");

  property p_id_quiet;
    writeInProgressFlag |-> !st.doutEn;
  endproperty
  a_id_quiet: assert property (p_id_quiet) else $error("id driven during cycle");

endmodule : serial_flash_sequencer

// ==== design/flash_seq_defines.svh ====
// Purpose: named constants of the flash command sequencer
// Assumes: one 200 MHz clock
// Notes:   times are plain defaults; the cycle counts derive from them
`ifndef FLASH_SEQ_DEFINES_SVH
`define FLASH_SEQ_DEFINES_SVH

// ****************************************************************
// opcodes
// ****************************************************************
`define OPC_WR_ENABLE   8'h06
`define OPC_WR_DISABLE  8'h04
`define OPC_QUAD_PROG   8'h32
`define OPC_SECT_WIPE   8'h20
`define OPC_BLK32_WIPE  8'h52
`define OPC_BLK64_WIPE  8'hd8
`define OPC_CHIP_WIPE_A 8'h60
`define OPC_CHIP_WIPE_B 8'hc7
`define OPC_SLEEP       8'hb9
`define OPC_WAKE_ID     8'hab
`define OPC_RST_ENABLE  8'h66
`define OPC_RST         8'h99

// ****************************************************************
// array operation kinds
// ****************************************************************
`define OPK_NONE  3'h0
`define OPK_PROG  3'h1
`define OPK_SECT  3'h2
`define OPK_BLK32 3'h3
`define OPK_BLK64 3'h4
`define OPK_CHIP  3'h5

// ****************************************************************
// framing and reset values
// ****************************************************************
`define PAGE_BYTES     256
`define LAST_ADDR_BYTE 2'h2
`define LAST_DUMMY     2'h2
`define ID_MSB         3'h7
`define SERIAL_STEP    3'h1
`define QUAD_STEP      3'h4
`define WEL_RESET      1'b0
`define DPD_RESET      1'b0

// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS  5
`define T_PROG_US      600
`define T_SECT_MS      50
`define T_BLK32_MS     150
`define T_BLK64_MS     250
`define T_CHIP_MS      2000
`define T_SLEEP_NS     3000
`define T_WAKE_NS      3000
`define T_WAKE_ID_NS   3000

`endif

// ==== design/flash_seq_pkg.sv ====
// Purpose: state types of the flash command sequencer
// Assumes: flash_seq_defines.svh gives the sizes
// Notes:   each module keeps all its state in one struct
`include "flash_seq_defines.svh"

package flash_seq_pkg;

  typedef enum logic [2:0] {PH_OPCODE, PH_ADDR, PH_DATA, PH_DONE,
                            PH_DUMMY, PH_ID, PH_IGNORE} phase_e;

  typedef enum logic [1:0] {USE_NONE, USE_WORK, USE_SLEEP, USE_WAKE} use_e;

  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic [5:0] prev;
    logic [7:0] sh;
    logic [2:0] bits;
    logic       rxValid;
    logic [7:0] rxByte;
  } shifter_s;

  typedef struct packed {
    logic [31:0] cnt;
    logic        busy;
    logic        done;
  } timer_s;

  typedef struct packed {
    phase_e                           phase;
    logic [7:0]                       opcode;
    logic [1:0]                       cnt;
    logic [23:0]                      addr;
    logic [7:0]                       ptr;
    logic                             anyData;
    logic [`PAGE_BYTES-1:0][7:0]      pageBuf;
    logic [`PAGE_BYTES-1:0]           pageValid;
    logic                             write_enable_latch;
    logic                             dpd;
    logic                             rstArmed;
    logic                             quad;
    use_e                             job;
    logic [2:0]                       idBit;
    logic                             dout;
    logic                             doutEn;
    logic                             opStart;
    logic [2:0]                       opKind;
    logic [23:0]                      opAddr;
    logic                             tStart;
    logic [31:0]                      tLoad;
  } seq_s;

endpackage : flash_seq_pkg

// ==== design/cmd_link_if.sv ====
// Purpose: carries received bytes and pin events to the sequencer
// Assumes: both ends on ref_clk
// Notes:   rx end is the shifter, seq end the sequencer
`timescale 1ns/1ps

interface cmd_link_if;
  logic       csLow;
  logic       csRise;
  logic       sclkFall;
  logic       rxValid;
  logic [7:0] rxByte;
  logic       partial;
  logic       quadMode;

  modport rx  (output csLow, csRise, sclkFall, rxValid, rxByte, partial,
               input quadMode);
  modport seq (input csLow, csRise, sclkFall, rxValid, rxByte, partial,
               output quadMode);
endinterface : cmd_link_if

// ==== design/spi_shifter.sv ====
// Purpose: samples the pins and assembles bytes on serial clock rises
// Assumes: serial clock far slower than ref_clk
// Notes:   one bit per edge, four in quad mode, high nibble first
`timescale 1ns/1ps

module spi_shifter (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // pins
  input  wire logic       chipSelectN,
  input  wire logic       serialClk,
  input  wire logic [3:0] quadDataIn,
  // sequencer side
  cmd_link_if.rx          lk
);

  flash_seq_pkg::shifter_s st;
  flash_seq_pkg::shifter_s next_st;

  always_comb begin
    logic [7:0] shv;
    logic [2:0] nb;
    shv = lk.quadMode ? {st.sh[3:0], st.s2[3:0]} : {st.sh[6:0], st.s2[0]};
    nb = st.bits + (lk.quadMode ? `QUAD_STEP : `SERIAL_STEP);
    next_st = st;
    next_st.s1 = {chipSelectN, serialClk, quadDataIn};
    next_st.s2 = st.s1;
    next_st.prev = st.s2;
    next_st.rxValid = 1'b0;
    if (st.s2[5]) begin
      next_st.bits = 3'h0;
    end else if (st.s2[4] && !st.prev[4]) begin
      next_st.sh = shv;
      next_st.bits = nb;
      if (nb == 3'h0) begin
        next_st.rxValid = 1'b1;
        next_st.rxByte = shv;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= '{s1: 6'h20, s2: 6'h20, prev: 6'h20, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign lk.csLow    = !st.s2[5];
  assign lk.csRise   = st.s2[5] && !st.prev[5];
  assign lk.sclkFall = !st.s2[5] && !st.s2[4] && st.prev[4];
  assign lk.rxValid  = st.rxValid;
  assign lk.rxByte   = st.rxByte;
  assign lk.partial  = st.bits != 3'h0;

endmodule : spi_shifter

// ==== design/wait_timer.sv ====
// Purpose: down counter for self-timed cycles and mode delays
// Assumes: load of zero is taken as one
// Notes:   done is a one-cycle pulse as busy falls
`timescale 1ns/1ps

module wait_timer (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // control
  input  wire logic        start,
  input  wire logic [31:0] load,
  // status
  output logic             busy,
  output logic             done
);

  flash_seq_pkg::timer_s st;
  flash_seq_pkg::timer_s next_st;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (start) begin
      next_st.cnt = (load == 32'h0) ? 32'h1 : load;
      next_st.busy = 1'b1;
    end else if (st.busy) begin
      next_st.cnt = st.cnt - 32'h1;
      if (st.cnt == 32'h1) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy = st.busy;
  assign done = st.done;

endmodule : wait_timer

// ==== tb/host_model.sv ====
// Purpose: host controller model on the flash pins
// Assumes: serial clock stands low between frames
// Notes:   released lines show the inverse of the last value
`timescale 1ns/1ps
module host_model (
  // pins
  input  wire logic       idLine,
  output logic            chipSelectN,
  output logic            serialClk,
  output logic      [3:0] dq
);
  logic [7:0] rx;
  initial {chipSelectN, serialClk, dq} = 6'h20;
  task nib(input logic [3:0] v);
    dq = v;
    #40 serialClk = 1'b1;
    rx = {rx[6:0], idLine};
    #40 serialClk = 1'b0;
  endtask : nib
  // opcode, address bytes, data bytes, loose bits
  task frame(input logic [7:0] op, input int na, input int nd, input logic q, input int lo);
    logic [7:0] b;
    #200 chipSelectN = 1'b0;
    for (int i = 7; i >= 0; i--) nib({~dq[3:1], op[i]});
    for (int i = 8 * na - 1; i >= 0; i--) nib({~dq[3:1], 1'(24'h0000fe >> i)});
    for (int k = 0; k < nd; k++) begin
      b = 8'(8'h10 + k + k / 256);
      if (q) begin
        nib(b[7:4]);
        nib(b[3:0]);
      end else for (int i = 7; i >= 0; i--) nib({~dq[3:1], b[i]});
    end
    for (int i = 0; i < lo; i++) nib(~dq);
    #40 chipSelectN = 1'b1;
    dq = ~dq;
  endtask : frame
endmodule : host_model

// ==== tb/serial_flash_program_erase_power_test.sv ====
// Purpose: self-checking bench of the flash command sequencer
// Assumes: host_model drives the pins
// Notes:   row: op, addr bytes, quad, qe, protect, complement, latch, loose, kind
`timescale 1ns/1ps
module serial_flash_program_erase_power_test;
  typedef struct packed {
    logic [7:0] op;
    logic [1:0] na;
    logic       q, qe, pr, c, we;
    logic [1:0] lo;
    logic [2:0] k;
  } row_s;
  row_s rows [14] = '{20'h32f21, 20'h32e20, 20'h32f00, 20'h32fa0, 20'h32f28, 20'h20c22,
    20'h52c23, 20'hd8c24, 20'h20ca0, 20'h20c28, 20'h60065, 20'hc7025, 20'hc70a0, 20'h60028};
  logic ref_clk = 1'b0, rst = 1'b1, quadEnableBit = 1'b0, protectComplementBit = 1'b0;
  logic targetProtected = 1'b0, chipSelectN, serialClk, writeInProgressFlag;
  logic writeEnableLatch, deepPowerDown, opStart, pageRdValid;
  logic [4:0] blockProtectBits = 5'h00;
  logic [7:0] pageRdIdx = 8'h00, pageRdData;
  logic [3:0] hostDq, quadDataIn, quadDataOut, quadDataOe;
  logic [2:0] targetKind, opKind;
  logic [23:0] targetAddr, opAddr;
  int err_count = 0, n_compared = 0;
  assign quadDataIn = (quadDataOe & quadDataOut) | (~quadDataOe & hostDq);
  host_model u_host (.idLine(quadDataIn[1]), .chipSelectN, .serialClk, .dq(hostDq));
  serial_flash_sequencer #(.PROG_CYCLES(20), .SECT_CYCLES(400), .BLK32_CYCLES(20),
    .BLK64_CYCLES(20), .CHIP_CYCLES(20)) u_dut (.ref_clk, .rst, .chipSelectN,
    .serialClk, .quadDataIn, .quadDataOut, .quadDataOe, .quadEnableBit, .blockProtectBits,
    .protectComplementBit, .targetAddr, .targetKind, .targetProtected, .writeInProgressFlag,
    .writeEnableLatch, .deepPowerDown, .opStart, .opKind, .opAddr, .pageRdIdx, .pageRdData,
    .pageRdValid);
  initial forever #2.5 ref_clk = ~ref_clk;
  task check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task close_out;
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task cmd(input logic [7:0] op, input int na, input int nd, input int w);
    u_host.frame(op, na, nd, 1'b0, 0);
    repeat (w) @(negedge ref_clk);
  endtask : cmd
  task run_row(input row_s r);
    logic [2:0] seen;
    seen = 3'h0;
    @(negedge ref_clk);
    {quadEnableBit, protectComplementBit, targetProtected} = {r.qe, r.c, r.pr};
    blockProtectBits = {2'h0, {3{r.c}}} | {4'h0, r.pr};
    if (r.we) cmd(8'h06, 0, 0, 0);
    u_host.frame(r.op, r.na, r.q ? 3 : 0, r.q, r.lo);
    repeat (500) begin
      @(negedge ref_clk);
      if (opStart === 1'b1) seen = opKind;
      if (opStart === 1'b1) check("flag", writeInProgressFlag, 1'b1);
      if (opStart === 1'b1 && r.k != 3'h5) check("opaddr", opAddr, 24'h0000fe);
    end
    if (r.na != 2'h0) check("target", targetAddr, 24'h0000fe);
    if (r.k != 3'h0) check("tkind", targetKind, r.k);
    check("kind", seen, r.k);
    check("latch", writeEnableLatch, r.we & (r.k == 3'h0));
    check("idle", writeInProgressFlag, 1'b0);
    cmd(8'h04, 0, 0, 0);
  endtask : run_row
  initial begin
    #300000 err_count++;
    close_out();
  end
  initial begin
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    check("sleep", deepPowerDown, 1'b0);
    check("latch", writeEnableLatch, 1'b0);
    foreach (rows[i]) run_row(rows[i]);
    @(negedge ref_clk) quadEnableBit = 1'b1;
    u_host.frame(8'h32, 3, 3, 1'b1, 0);
    @(negedge ref_clk) pageRdIdx = 8'h01;
    @(negedge ref_clk) check("valid", pageRdValid, 1'b0);
    pageRdIdx = 8'h00;
    @(negedge ref_clk) check("wrap", pageRdData, 8'h12);
    u_host.frame(8'h32, 3, 257, 1'b1, 0);
    @(negedge ref_clk) pageRdIdx = 8'hfe;
    @(negedge ref_clk) check("last", pageRdData, 8'h11);
    cmd(8'hb9, 0, 0, 700);
    check("sleep", deepPowerDown, 1'b1);
    cmd(8'h06, 0, 0, 10);
    check("latch", writeEnableLatch, 1'b0);
    cmd(8'hab, 0, 0, 700);
    check("sleep", deepPowerDown, 1'b0);
    cmd(8'hb9, 0, 0, 700);
    cmd(8'hab, 3, 2, 700);
    check("id", u_host.rx, 8'h5a);
    check("sleep", deepPowerDown, 1'b0);
    cmd(8'hb9, 0, 0, 700);
    check("sleep", deepPowerDown, 1'b1);
    cmd(8'h66, 0, 0, 0);
    cmd(8'h99, 0, 0, 10);
    check("sleep", deepPowerDown, 1'b0);
    cmd(8'h06, 0, 0, 0);
    cmd(8'h20, 3, 0, 0);
    cmd(8'hb9, 0, 0, 1);
    check("flag", writeInProgressFlag, 1'b1);
    repeat (700) @(negedge ref_clk);
    check("sleep", deepPowerDown, 1'b0);
    close_out();
  end
endmodule : serial_flash_program_erase_power_test
